/* File: pkg/cps_pkg.sv */
// Constants, types and helpers for the codec port slot and command register block.
// Assumes an AXI4-Lite master with 32-bit data and a 25 MHz mclk.
// Functional notes
// [RULE_01] Low data register holds command/status bits 7:0; narrow modes exchange only it.
// [RULE_02] A write transaction sends the loaded command word to the codec.
// [RULE_03] A read transaction overwrites the data registers with the codec's status word.
// [RULE_04] High data register holds bits 15:8 and is ignored in narrow modes.
// [RULE_05] Low valid-slot bits 7 down to 3 map to slots 8 through 12.
// [RULE_06] High valid-slot bits 4 down to 0 map to slots 3 through 7.
// [RULE_07] A slot carries valid data only while its valid bit is one.
// [RULE_08] Frame-valid bit 7 marks a frame holding at least one valid slot.
// [RULE_09] Slot 0 bit 15 from primary codec sets read-only ready flag bit 6.
// [RULE_10] Slot 0 bit 15 from secondary codec sets read-only ready flag bit 5.
// [RULE_11] Valid-slot registers and ready flags act only in the AC '97 mode.
// [RULE_12] Bits 5:3 pick data bits per slot: 8,16,18,20,24,32; rest reserved.
// [RULE_13] Data bits per slot never apply to command address and data slots.
// [RULE_14] Bits 2:0 pick bit-clock cycles per slot: 8,16,18,20,24,32; rest reserved.
// [RULE_15] The slot format register is used only in I2S mode 5.
// [RULE_16] Reserved bits are read-only and read as zero.
// [RULE_17] Direction bit one requests a codec register read, zero a write.
// [RULE_18] Short data goes first, MSB first, the rest of the slot is zeros.
package cps_pkg;
   localparam int          AXI_AW       = 18;
   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_RX_FMT   = 16'hFFD6;
   localparam logic [15:0] IDX_VSL_HI   = 16'hFFD7;
   localparam logic [15:0] IDX_VSL_LO   = 16'hFFD8;
   localparam logic [15:0] IDX_DAT_HI   = 16'hFFD9;
   localparam logic [15:0] IDX_DAT_LO   = 16'hFFDA;
   localparam logic [15:0] IDX_CMD_ADR  = 16'hFFDB;
   localparam logic [15:0] IDX_CTRL     = 16'hFFE0;
   localparam logic [15:0] IDX_IRQ_ST   = 16'hFFE1;
   localparam logic [15:0] IDX_IRQ_MSK  = 16'hFFE2;
   localparam logic [7:0]  RST_REG8     = 8'h00;
   localparam logic [1:0]  RST_IRQ      = 2'h0;
   localparam int          CTRL_START   = 2;
   localparam int          IRQ_DONE     = 0;
   localparam int          IRQ_FRAME    = 1;
   localparam int          TAG_READY    = 15;
   localparam logic [3:0]  LAST_SLOT    = 4'hC;
   localparam logic [5:0]  AC97_TAG_LEN = 6'h10;
   localparam logic [5:0]  AC97_SLOT    = 6'h14;
   localparam logic [5:0]  NARROW_SLOT  = 6'h10;
   localparam logic [5:0]  BYTE_BITS    = 6'h08;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   typedef enum logic [1:0] {MODE_GP, MODE_AC97, MODE_ALT, MODE_I2S5} cps_mode_t;
   typedef enum logic [1:0] {CMD_IDLE, CMD_ARMED, CMD_SEND, CMD_RESP} cps_cmd_t;
   typedef enum logic {LNK_IDLE, LNK_RUN} cps_lnk_t;

   typedef struct packed {
      logic [2:0] bits_per_slot;
      logic [2:0] slot_length_cycles;
   } cps_fmt_t;

   typedef struct packed {
      logic       frame_valid;
      logic       primary_codec_ready;
      logic       secondary_codec_ready;
      logic [4:0] slot_valid_bit;
   } cps_vsl_hi_t;

   typedef struct packed {
      logic       rw;
      logic [6:0] addr;
   } cps_cmd_adr_t;

   function automatic logic [5:0] code_cycles(input logic [2:0] c);
      // Reserved codes fall back to the widest setting
      case (c)
         3'h0:    return 6'h08;
         3'h1:    return 6'h10;
         3'h2:    return 6'h12;
         3'h3:    return 6'h14;
         3'h4:    return 6'h18;
         default: return 6'h20;
      endcase
   endfunction : code_cycles

   function automatic logic [5:0] slot_cycles(input cps_mode_t m, input logic [3:0] s,
                                              input logic [2:0] tsl);
      if (m == MODE_I2S5)
         return code_cycles(tsl);
      if (m == MODE_AC97)
         return (s == 4'h0) ? AC97_TAG_LEN : AC97_SLOT;
      return NARROW_SLOT;
   endfunction : slot_cycles

   function automatic logic [5:0] data_bits(input cps_mode_t m, input logic [3:0] s,
                                            input cps_fmt_t f);
      logic [5:0] len;
      logic [5:0] bps;
      len = slot_cycles(m, s, f.slot_length_cycles);
      bps = code_cycles(f.bits_per_slot);
      if (m != MODE_I2S5 || s == 4'h1 || s == 4'h2)
         return len;
      return (bps < len) ? bps : len;
   endfunction : data_bits
endpackage : cps_pkg

/* File: src/cps_codec_regs.sv */
// Codec port command/status data, valid-slot and slot-format registers with slot engine.
// Assumes an AXI4-Lite master on mclk and a codec bit clock far slower than mclk.
module cps_codec_regs
   import cps_pkg::*;
(
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // AXI4-Lite write
   input  wire logic [AXI_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [AXI_AW-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Codec link
   input  wire logic              codec_bit_clock,
   input  wire logic              frame_sync,
   input  wire logic              sdata_in,
   input  wire logic              sdata_in2,
   output logic                   sdata_out,
   // Playback sample, MSB-justified
   input  wire logic [31:0]       play_sample,
   // Interrupt
   output logic                   irq
);
   cps_fmt_t     rx_fmt;
   cps_vsl_hi_t  vsl_hi;
   logic [4:0]   vsl_lo;
   logic [7:0]   dat_hi;
   logic [7:0]   dat_lo;
   cps_cmd_adr_t cmd_adr;
   cps_mode_t    mode;
   cps_cmd_t     cmd_st;
   cps_lnk_t     lnk;
   logic [1:0]   irq_st;
   logic [1:0]   irq_msk;
   logic         aw_held;
   logic         w_held;
   logic [15:0]  aw_idx;
   logic [15:0]  rd_idx;
   logic [7:0]   w_byte;
   logic         w_lane;
   logic [3:0]   pin_m;
   logic [3:0]   pin_s;
   logic         bclk_d;
   logic         sync_prev;
   logic [3:0]   tx_slot;
   logic [5:0]   tx_bit;
   logic [31:0]  tx_sh;
   logic [15:0]  tx_tag;
   logic [31:0]  rx_sh;
   logic [15:0]  rx_sh2;
   logic         rx_tag_ok;

   logic         do_write;
   logic         wr_fmt, wr_vhi, wr_vlo, wr_dhi, wr_dlo, wr_adr, wr_ctrl, wr_ist, wr_imsk;
   logic         wr_hit;
   logic [7:0]   rd_byte;
   logic         rd_hit;
   logic         bclk_rise, bclk_fall, frame_start, ac97;
   logic [5:0]   cur_len;
   logic         rx_end;
   logic [31:0]  rx_word;
   logic [15:0]  rx_word2;
   logic [15:0]  next_tag;
   logic [3:0]   load_slot;
   logic [31:0]  load_word;
   logic         resp_ok, cap_dat, cmd_done;
   logic [1:0]   irq_ev;

   // Bus write decode
   always_comb
   begin
      do_write = aw_held && w_held && !s_axi_bvalid;
      wr_fmt   = do_write && w_lane && aw_idx == IDX_RX_FMT;
      wr_vhi   = do_write && w_lane && aw_idx == IDX_VSL_HI;
      wr_vlo   = do_write && w_lane && aw_idx == IDX_VSL_LO;
      wr_dhi   = do_write && w_lane && aw_idx == IDX_DAT_HI;
      wr_dlo   = do_write && w_lane && aw_idx == IDX_DAT_LO;
      wr_adr   = do_write && w_lane && aw_idx == IDX_CMD_ADR;
      wr_ctrl  = do_write && w_lane && aw_idx == IDX_CTRL;
      wr_ist   = do_write && w_lane && aw_idx == IDX_IRQ_ST;
      wr_imsk  = do_write && w_lane && aw_idx == IDX_IRQ_MSK;
      wr_hit   = aw_idx inside {IDX_RX_FMT, IDX_VSL_HI, IDX_VSL_LO, IDX_DAT_HI, IDX_DAT_LO,
                                IDX_CMD_ADR, IDX_CTRL, IDX_IRQ_ST, IDX_IRQ_MSK};
   end

   // Bus read mux; reserved bits come back zero
   always_comb
   begin
      rd_hit  = 1'b1;
      rd_byte = 8'h00;
      unique case (s_axi_araddr[AXI_AW-1:2])
         IDX_RX_FMT:  rd_byte = {2'b00, rx_fmt};                         // [RULE_16]
         IDX_VSL_HI:  rd_byte = vsl_hi;
         IDX_VSL_LO:  rd_byte = {vsl_lo, 3'b000};                        // [RULE_16]
         IDX_DAT_HI:  rd_byte = dat_hi;
         IDX_DAT_LO:  rd_byte = dat_lo;
         IDX_CMD_ADR: rd_byte = cmd_adr;
         IDX_CTRL:    rd_byte = {5'h00, cmd_st != CMD_IDLE, mode};
         IDX_IRQ_ST:  rd_byte = {6'h00, irq_st};
         IDX_IRQ_MSK: rd_byte = {6'h00, irq_msk};
         default:     rd_hit  = 1'b0;
      endcase
   end

   // Write channel: address and data taken in either order
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_idx        <= 16'h0000;
         w_byte        <= 8'h00;
         w_lane        <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held       <= 1'b1;
            aw_idx        <= s_axi_awaddr[AXI_AW-1:2];
            s_axi_awready <= 1'b0;
         end
         else if (!aw_held && !s_axi_bvalid)
            s_axi_awready <= 1'b1;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held       <= 1'b1;
            w_byte       <= s_axi_wdata[7:0];
            w_lane       <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         else if (!w_held && !s_axi_bvalid)
            s_axi_wready <= 1'b1;
         if (do_write)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
         rd_idx        <= 16'h0000;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h00_0000, rd_byte};
         s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         rd_idx        <= s_axi_araddr[AXI_AW-1:2];
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid)
         s_axi_arready <= 1'b1;
   end

   // Software-owned configuration and codec ready flags
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rx_fmt                <= cps_fmt_t'(RST_REG8[5:0]);
         vsl_hi.frame_valid    <= RST_REG8[7];
         vsl_hi.slot_valid_bit <= RST_REG8[4:0];
         vsl_lo                <= RST_REG8[7:3];
         mode                  <= MODE_GP;
         irq_msk               <= RST_IRQ;
         vsl_hi.primary_codec_ready   <= RST_REG8[6];
         vsl_hi.secondary_codec_ready <= RST_REG8[5];
      end
      else
      begin
         if (wr_fmt)
            rx_fmt <= cps_fmt_t'(w_byte[5:0]);                           // [RULE_12] [RULE_14]
         if (wr_vhi)
         begin
            vsl_hi.frame_valid    <= w_byte[7];                         // [RULE_08]
            vsl_hi.slot_valid_bit <= w_byte[4:0];                       // [RULE_06]
         end
         if (wr_vlo)
            vsl_lo <= w_byte[7:3];                                      // [RULE_05]
         if (wr_ctrl)
            mode <= cps_mode_t'(w_byte[1:0]);
         if (wr_imsk)
            irq_msk <= w_byte[1:0];
         // Ready flags share the word with software bits, so one process owns it
         if (rx_end && tx_slot == 4'h0 && ac97)                         // [RULE_11]
         begin
            vsl_hi.primary_codec_ready   <= rx_word[TAG_READY];         // [RULE_09]
            vsl_hi.secondary_codec_ready <= rx_word2[TAG_READY];        // [RULE_10]
         end
      end
   end

   // Pin synchronisers; only the second stage is read
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         pin_m  <= 4'h0;
         pin_s  <= 4'h0;
         bclk_d <= 1'b0;
      end
      else
      begin
         pin_m  <= {sdata_in2, sdata_in, frame_sync, codec_bit_clock};
         pin_s  <= pin_m;
         bclk_d <= pin_s[0];
      end
   end

   always_comb
   begin
      ac97        = mode == MODE_AC97;
      bclk_rise   = pin_s[0] && !bclk_d;
      bclk_fall   = !pin_s[0] && bclk_d;
      frame_start = bclk_rise && pin_s[1] && !sync_prev;
      cur_len     = slot_cycles(mode, tx_slot, rx_fmt.slot_length_cycles);  // [RULE_15]
      rx_end      = bclk_fall && lnk == LNK_RUN && tx_bit == cur_len - 6'h01;
      rx_word     = {rx_sh[30:0], pin_s[2]};
      rx_word2    = {rx_sh2[14:0], pin_s[3]};
      // Tag slot exists only in AC '97; slot k valid sits at tag bit 15-k
      next_tag    = ac97 ? {vsl_hi.frame_valid, cmd_st == CMD_ARMED,      // [RULE_11] [RULE_08]
                            cmd_st == CMD_ARMED && !cmd_adr.rw,
                            vsl_hi.slot_valid_bit, vsl_lo, 3'b000} : 16'h0000; // [RULE_05] [RULE_06]
   end

   // Word for the slot that starts at this bit-clock rise
   always_comb
   begin
      load_slot = frame_start ? 4'h0 : tx_slot + 4'h1;
      load_word = 32'h0000_0000;
      if (load_slot == 4'h0 && ac97)
         load_word = {next_tag, 16'h0000};
      else if (load_slot == 4'h1)
      begin
         if (cmd_st == CMD_SEND)
            load_word = {cmd_adr, 24'h00_0000};                         // [RULE_17]
      end
      else if (load_slot == 4'h2)
      begin
         if (cmd_st == CMD_SEND && !cmd_adr.rw)                         // [RULE_02]
            load_word = ac97 ? {dat_hi, dat_lo, 16'h0000}
                             : {dat_lo, 24'h00_0000};                   // [RULE_01] [RULE_04]
      end
      else if (mode == MODE_I2S5 || (ac97 && tx_tag[15] && tx_tag[4'hF - load_slot])) // [RULE_07]
         // Only the top data bits survive; the slot tail shifts out as zeros
         load_word = play_sample
                   & ~(32'hFFFF_FFFF >> data_bits(mode, load_slot, rx_fmt)); // [RULE_13] [RULE_18]
   end

   // Slot engine on the bit clock's rising edges
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         lnk       <= LNK_IDLE;
         sync_prev <= 1'b0;
         tx_slot   <= 4'h0;
         tx_bit    <= 6'h00;
         tx_sh     <= 32'h0000_0000;
         tx_tag    <= 16'h0000;
         sdata_out <= 1'b0;
      end
      else if (bclk_rise)
      begin
         sync_prev <= pin_s[1];
         if (frame_start || (lnk == LNK_RUN && tx_bit == cur_len - 6'h01 && tx_slot != LAST_SLOT))
         begin
            lnk       <= LNK_RUN;
            tx_slot   <= load_slot;
            tx_bit    <= 6'h00;
            sdata_out <= load_word[31];
            tx_sh     <= {load_word[30:0], 1'b0};
            if (frame_start)
               tx_tag <= next_tag;
         end
         else if (lnk == LNK_RUN && tx_bit == cur_len - 6'h01)
         begin
            lnk       <= LNK_IDLE;
            sdata_out <= 1'b0;
         end
         else if (lnk == LNK_RUN)
         begin
            tx_bit    <= tx_bit + 6'h01;
            sdata_out <= tx_sh[31];                                     // [RULE_18]
            tx_sh     <= {tx_sh[30:0], 1'b0};
         end
      end
   end

   // Receive shifting and slot 0 tag capture
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rx_sh                        <= 32'h0000_0000;
         rx_sh2                       <= 16'h0000;
         rx_tag_ok                    <= 1'b0;
      end
      else if (bclk_fall && lnk == LNK_RUN)
      begin
         rx_sh  <= rx_word;
         rx_sh2 <= rx_word2;
         if (rx_end && tx_slot == 4'h0 && ac97)
            rx_tag_ok <= rx_word[14] && rx_word[13];
      end
   end

   always_comb
   begin
      resp_ok  = rx_end && cmd_st == CMD_RESP && (!ac97 || rx_tag_ok);
      cap_dat  = resp_ok && tx_slot == 4'h2;
      cmd_done = cap_dat
              || (rx_end && tx_slot == LAST_SLOT && cmd_st == CMD_SEND && !cmd_adr.rw);
      irq_ev   = {frame_start, cmd_done};
   end

   // Command data and address; a returned status word beats a bus write
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         dat_hi  <= RST_REG8;
         dat_lo  <= RST_REG8;
         cmd_adr <= cps_cmd_adr_t'(RST_REG8);
      end
      else
      begin
         if (cap_dat && ac97)
         begin
            dat_hi <= rx_word[19:12];                                   // [RULE_03]
            dat_lo <= rx_word[11:4];
         end
         else if (cap_dat)
            dat_lo <= 8'(rx_word >> (cur_len - BYTE_BITS));              // [RULE_01] [RULE_04]
         else
         begin
            if (wr_dhi)
               dat_hi <= w_byte;
            if (wr_dlo)
               dat_lo <= w_byte;
         end
         if (resp_ok && ac97 && tx_slot == 4'h1)
            cmd_adr.addr <= rx_word[18:12];
         else if (wr_adr)
            cmd_adr <= cps_cmd_adr_t'(w_byte);
      end
   end

   // Transaction sequencing
   always_ff @(posedge mclk)
   begin
      if (rst)
         cmd_st <= CMD_IDLE;
      else
      begin
         unique case (cmd_st)
            CMD_IDLE:
               if (wr_ctrl && w_byte[CTRL_START])
                  cmd_st <= CMD_ARMED;
            CMD_ARMED:
               if (frame_start)
                  cmd_st <= CMD_SEND;
            CMD_SEND:
               if (rx_end && tx_slot == LAST_SLOT)
                  cmd_st <= cmd_adr.rw ? CMD_RESP : CMD_IDLE;           // [RULE_17]
            CMD_RESP:
               if (cap_dat)
                  cmd_st <= CMD_IDLE;
         endcase
      end
   end

   // Sticky events, write one to clear; a new event wins over the clear
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         irq_st <= RST_IRQ;
         irq    <= 1'b0;
      end
      else
      begin
         irq_st <= (irq_st & ~(wr_ist ? w_byte[1:0] : 2'b00)) | irq_ev;
         irq    <= |(irq_st & irq_msk);
      end
   end

   a_fmt_rsvd_zero: assert property (@(posedge mclk) disable iff (rst)     // [RULE_16]
      s_axi_rvalid && rd_idx == IDX_RX_FMT |-> s_axi_rdata[31:6] == 26'h000_0000)
      else $error("slot format reserved bits not zero");
   a_vlo_rsvd_zero: assert property (@(posedge mclk) disable iff (rst)     // [RULE_16]
      s_axi_rvalid && rd_idx == IDX_VSL_LO |-> s_axi_rdata[2:0] == 3'b000)
      else $error("valid slot low reserved bits not zero");
   a_tag_map: assert property (@(posedge mclk) disable iff (rst)           // [RULE_05]
      frame_start && ac97 |=> tx_tag[12:8] == $past(vsl_hi.slot_valid_bit)
                              && tx_tag[7:3] == $past(vsl_lo) && tx_tag[15] == $past(vsl_hi.frame_valid))
      else $error("slot valid tag mapping wrong");
   a_tag_on_wire: assert property (@(posedge mclk) disable iff (rst)       // [RULE_06]
      lnk == LNK_RUN && ac97 && tx_slot == 4'h0 && tx_bit == 6'h03 |-> sdata_out == tx_tag[12])
      else $error("slot 3 valid bit not on the wire");
   a_ready_copy: assert property (@(posedge mclk) disable iff (rst)        // [RULE_09]
      rx_end && tx_slot == 4'h0 && ac97
      |=> vsl_hi.primary_codec_ready == $past(rx_word[15])
          && vsl_hi.secondary_codec_ready == $past(rx_word2[15]))
      else $error("codec ready flags not copied");
   a_ready_frozen: assert property (@(posedge mclk) disable iff (rst)      // [RULE_11]
      !ac97 |=> $stable({vsl_hi.primary_codec_ready, vsl_hi.secondary_codec_ready}))
      else $error("ready flags moved outside AC 97 mode");
   a_read_capture: assert property (@(posedge mclk) disable iff (rst)      // [RULE_03]
      cap_dat && ac97 |=> dat_lo == $past(rx_word[11:4]) && dat_hi == $past(rx_word[19:12])
                          && cmd_st == CMD_IDLE)
      else $error("status word not captured");
   a_narrow_hi: assert property (@(posedge mclk) disable iff (rst)         // [RULE_04]
      cap_dat && !ac97 && !wr_dhi |=> $stable(dat_hi))
      else $error("high data touched in narrow mode");
   a_zero_fill: assert property (@(posedge mclk) disable iff (rst)         // [RULE_18]
      lnk == LNK_RUN && mode == MODE_I2S5 && tx_slot > 4'h2
      && tx_bit >= data_bits(mode, tx_slot, rx_fmt) |-> !sdata_out)
      else $error("slot tail not zero filled");
   a_write_done: assert property (@(posedge mclk) disable iff (rst)        // [RULE_02]
      rx_end && tx_slot == LAST_SLOT && cmd_st == CMD_SEND && !cmd_adr.rw
      |=> cmd_st == CMD_IDLE && irq_st[IRQ_DONE])
      else $error("write transaction not completed");
   a_irq_level: assert property (@(posedge mclk) disable iff (rst)
      |(irq_st & irq_msk) |=> irq ##1 1)
      else $error("interrupt not raised");
   a_bresp_time: assert property (@(posedge mclk) disable iff (rst)
      aw_held && w_held && !s_axi_bvalid |=> s_axi_bvalid)
      else $error("write response late");

   c_frame: cover property (@(posedge mclk) disable iff (rst) frame_start && ac97);
   c_cmd_write: cover property (@(posedge mclk) disable iff (rst) cmd_done && !cmd_adr.rw);
   c_cmd_read: cover property (@(posedge mclk) disable iff (rst) cap_dat && ac97);
   c_irq: cover property (@(posedge mclk) disable iff (rst) irq ##1 !irq);
endmodule : cps_codec_regs

/* File: testbench/cps_codec_model.sv */
// Codec model: bit clock, frame sync and serial data for one frame per call.
// Assumes the bench calls frame() while idle; the clock stands still between frames.
module cps_codec_model
(
   // Link to the block
   output logic      bclk,
   output logic      fsync,
   output logic      sdi,
   output logic      sdi2,
   input  wire logic sdo
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [255:0] tx = '0, rx = '0;
   initial {bclk, fsync, sdi, sdi2} = 4'h0;
   task automatic frame(input logic r1, input logic r2, input int n);
      #7;
      for (int k = -1; k < n + 2; k++)
      begin
         fsync = (k >= 0 && k < 16);
         sdi = (k == 0) ? r1 : (k < 3) | 1'($urandom);
         sdi2 = (k == 0) ? r2 : ~sdi2;
         bclk = 1;
         #160 bclk = 0;
         // Late sample: output may lag the rise by several block clocks
         #150 if (k >= 0 && k < n) {tx[255-k], rx[255-k]} = {sdo, sdi};
         #10;
      end
      sdi = ~sdi;
      sdi2 = ~sdi2;
   endtask : frame
endmodule : cps_codec_model

/* File: testbench/test_codec_port_slot_and_command_regs.sv */
// Bench: register bus tasks, AC97 command write and read frames, I2S5 command read frames, irq checks.
// Assumes the codec model drives the link only inside frames.
module test_codec_port_slot_and_command_regs
   import cps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
   logic [31:0]       wdata = '0, rdata, ps = '0;
   logic [1:0]        bresp, rresp;
   logic              awready, wready, bvalid, arready, rvalid, irq, bclk, fsync, sdi, sdi2, sdo;
   int                miscompares = 0, comparisons = 0, cyc = 0;
   localparam logic [15:0] IX[5] = '{IDX_RX_FMT, IDX_VSL_HI, IDX_VSL_LO, IDX_DAT_HI, IDX_DAT_LO};
   localparam logic [7:0]  MK[5] = '{8'h3F, 8'h9F, 8'hF8, 8'hFF, 8'hFF};
   cps_codec_regs cps_codec_regs_i(.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .codec_bit_clock(bclk), .frame_sync(fsync), .sdata_in(sdi),
      .sdata_in2(sdi2), .sdata_out(sdo), .play_sample(ps), .irq(irq));
   cps_codec_model cps_codec_model_i(.bclk(bclk), .fsync(fsync), .sdi(sdi), .sdi2(sdi2), .sdo(sdo));
   initial forever #20 mclk = ~mclk;
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         miscompares++;
         test_done;
      end
   end
   task automatic test_done;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [15:0] i, input logic [7:0] d);
      logic a = 1, w = 1;
      awaddr <= {i, 2'b00};
      wdata <= {24'h0, d};
      {awvalid, wvalid, bready} <= 3'h7;
      while (a | w)
      begin
         @(posedge mclk);
         a = a & !awready;
         w = w & !wready;
         awvalid <= a;
         wvalid <= w;
      end
      do @(posedge mclk); while (bvalid !== 1'b1);
      chk("bresp", bresp, RESP_OKAY);
      bready <= 0;
      @(posedge mclk);
   endtask : wr
   task automatic rc(input logic [15:0] i, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
      araddr <= {i, 2'b00};
      {arvalid, rready} <= 2'h3;
      do @(posedge mclk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge mclk); while (rvalid !== 1'b1);
      rready <= 0;
      chk("rdata", rdata, {24'h0, e});
      chk("rresp", rresp, er);
      @(posedge mclk);
   endtask : rc
   function automatic logic on(int s, logic [7:0] h, logic [7:0] l);
      return (s < 8) ? h[7-s] : l[15-s];
   endfunction : on
   initial
   begin
      logic [7:0] d, vh, vl, dh, dl, ad;
      logic       c;
      d = 8'($urandom(57187));
      repeat (10) @(posedge mclk);
      rst <= 0;
      repeat (2) @(posedge mclk);
      foreach (IX[j]) rc(IX[j], 8'h00);
      repeat (6) foreach (IX[j])
      begin
         d = 8'($urandom);
         wr(IX[j], d);
         rc(IX[j], d & MK[j]);
      end
      rc(16'h0100, 8'h00, RESP_SLVERR);
      {dh, dl, ad, vl} = $urandom;
      vh = 8'h80 | 8'($urandom % 32);
      ad[7] = 0;
      vl[2:0] = 0;
      ps <= $urandom;
      wr(IDX_VSL_HI, vh);
      wr(IDX_VSL_LO, vl);
      wr(IDX_DAT_HI, dh);
      wr(IDX_DAT_LO, dl);
      wr(IDX_CMD_ADR, ad);
      wr(IDX_CTRL, 8'h05);
      cps_codec_model_i.frame(1, 1, 256);
      @(posedge mclk);
      chk("slot0", cps_codec_model_i.tx[255-:16], {3'h7, vh[4:0], vl[7:3], 3'h0});
      chk("slot1", cps_codec_model_i.tx[239-:8], ad);
      chk("slot2", cps_codec_model_i.tx[219-:16], {dh, dl});
      for (int k = 3; k < 13; k++)
         chk("audio", cps_codec_model_i.tx[259-20*k-:20], on(k, vh, vl) ? ps[31:12] : 20'h0);
      rc(IDX_VSL_HI, vh | 8'h60);
      rc(IDX_IRQ_ST, 8'h03);
      chk("irq", irq, 1'b0);
      wr(IDX_IRQ_MSK, 8'h01);
      chk("irq", irq, 1'b1);
      wr(IDX_IRQ_ST, 8'h01);
      chk("irq", irq, 1'b0);
      rc(IDX_IRQ_ST, 8'h02);
      wr(IDX_CMD_ADR, 8'h80 | ad);
      wr(IDX_CTRL, 8'h05);
      repeat (2) cps_codec_model_i.frame(1, 1, 256);
      @(posedge mclk);
      {dh, dl} = cps_codec_model_i.rx[219-:16];
      rc(IDX_DAT_HI, dh);
      rc(IDX_DAT_LO, dl);
      rc(IDX_CMD_ADR, {1'b1, cps_codec_model_i.rx[238-:7]});
      chk("irq", irq, 1'b1);
      c = 1'($urandom);
      wr(IDX_RX_FMT, {4'h0, c, 3'h1});
      wr(IDX_CTRL, 8'h07);
      repeat (2) cps_codec_model_i.frame(0, 0, 208);
      @(posedge mclk);
      chk("i2s0", cps_codec_model_i.tx[255-:16], c ? ps[31:16] : {ps[31:24], 8'h00});
      chk("i2s5", cps_codec_model_i.tx[175-:16], c ? ps[31:16] : {ps[31:24], 8'h00});
      rc(IDX_VSL_HI, vh | 8'h60);
      rc(IDX_DAT_LO, cps_codec_model_i.rx[223-:8]);
      rc(IDX_DAT_HI, dh);
      test_done;
   end
endmodule : test_codec_port_slot_and_command_regs
